/* inc/atten_defs.svh */
// Constants of the serial attenuator control path.
`ifndef ATTEN_DEFS_SVH
`define ATTEN_DEFS_SVH

// -----------------------------------------------------------------------
// Frame layout
// -----------------------------------------------------------------------
`define FRAME_BITS     16
`define ADDR_MSB       15
`define ADDR_LSB       8
`define CODE_MSB       7
`define CODE_LSB       0

// -----------------------------------------------------------------------
// Attenuation codes and reset values
// -----------------------------------------------------------------------
`define MUTE_CODE      8'h7f
`define NUM_TAPS       127
`define NUM_CHANNELS   2
`define CODE_RESET     8'h7f
`define SYNC_STAGES    2

`endif

/* inc/atten_pkg.sv */
// Types shared by the serial attenuator control path.
package atten_pkg;

    typedef logic [7:0]  att_code_t;
    typedef logic [7:0]  ch_addr_t;
    typedef logic [15:0] frame_word_t;

endpackage

/* inc/atten_ch_if.sv */
// Command and status signals between the decoder and one channel.
`timescale 1ns/10ps
interface atten_ch_if;
    import atten_pkg::*;

    logic        wr;
    att_code_t   code;
    logic [126:0] tap;
    logic        mute;

    modport ctrl (output wr, output code, input tap, input mute);
    modport chan (input wr, input code, output tap, output mute);
endinterface

/* logic/atten_channel.sv */
// One attenuator channel: stored code, mute flag and one-hot tap select.
`timescale 1ns/10ps
`include "atten_defs.svh"
module atten_channel
    import atten_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    atten_ch_if.chan  cmd
);

    att_code_t     code_reg;
    att_code_t     code_next;
    logic          mute_next;
    logic [126:0]  tap_next;
    logic          mute_reg;
    logic [126:0]  tap_reg;

    // -------------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------------
    assign code_next = cmd.wr ? cmd.code : code_reg;
    assign mute_next = (code_next >= `MUTE_CODE);
    assign tap_next  = mute_next ? '0
                     : (127'(1) << code_next[6:0]);

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            code_reg <= `CODE_RESET;
            mute_reg <= 1'b1;
            tap_reg  <= '0;
        end
        else
        begin
            code_reg <= code_next;
            mute_reg <= mute_next;
            tap_reg  <= tap_next;
        end
    end

    assign cmd.tap  = tap_reg;
    assign cmd.mute = mute_reg;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    property p_ch_hold;
        @(posedge clk) disable iff (!nrst)
        !cmd.wr |=> $stable(code_reg) && $stable(tap_reg);
    endproperty
    a_ch_hold: assert property (p_ch_hold)
        else $error("Channel changed without a command.");

    property p_ch_mute;
        @(posedge clk) disable iff (!nrst)
        cmd.wr && (cmd.code >= `MUTE_CODE) |=> mute_reg && (tap_reg == '0);
    endproperty
    a_ch_mute: assert property (p_ch_mute)
        else $error("Mute code did not mute the channel.");

    property p_ch_tap;
        @(posedge clk) disable iff (!nrst)
        cmd.wr && (cmd.code < `MUTE_CODE)
            |=> !mute_reg && tap_reg[$past(cmd.code[6:0])] && $onehot(tap_reg);
    endproperty
    a_ch_tap: assert property (p_ch_tap)
        else $error("Tap select is not the one requested.");

    property p_ch_isolate;
        @(posedge clk) disable iff (!nrst)
        mute_reg |-> (tap_reg == '0);
    endproperty
    a_ch_isolate: assert property (p_ch_isolate)
        else $error("A tap is active while muted.");

    property p_ch_powerup;
        @(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> mute_reg;
    endproperty
    a_ch_powerup: assert property (p_ch_powerup)
        else $error("Channel not muted after reset.");

endmodule // atten_channel

/* logic/serial_attenuator_control.sv */
// Serial link front end, frame capture and channel decode of the attenuator.
`timescale 1ns/10ps
`include "atten_defs.svh"
// Functional notes
// - Serial bits shift into a register, are captured, then decoded.
// - Bits leaving the shift register appear on the cascade output.
// - Rising frame line captures the shift register as a new command.
// - Captured command drives the tap select of the named channel.
// - A channel changes only when a command selects it, or at reset.
// - Every channel is muted after power-up.
// - One frame line rise makes every chained device capture at once.
// - Address byte picks the channel; code byte applies only there.
// - Each channel has its own one-hot tap select from its code.
// - A muted channel asserts its isolation control.
// - Frame is address byte then code byte, each MSB first.
// - Serial bits are accepted only while the frame line is low.
// - Address 0 is channel one, 1 channel two; others change nothing.
// - Codes 0x7f through 0xff mute; lower codes select a step.
module serial_attenuator_control
    import atten_pkg::*;
#(
    parameter int NUM_CH = `NUM_CHANNELS
)
(
    input  wire logic                 CLK_SYS,
    input  wire logic                 NRST,
    input  wire logic                 SCLK,
    input  wire logic                 SDI,
    input  wire logic                 FRAME_N,
    output wire logic                 SDO,
    output wire logic [NUM_CH*127-1:0] TAP_SEL,
    output wire logic [NUM_CH-1:0]    MUTE
);

    // -------------------------------------------------------------------
    // Parameter check
    // -------------------------------------------------------------------
    if (NUM_CH < 1 || NUM_CH > 256)
    begin : g_bad_param
        $error("NUM_CH must lie between 1 and 256.");
    end

    // -------------------------------------------------------------------
    // Link domain: reset synchroniser and shift register
    // -------------------------------------------------------------------
    logic        lrst_meta_reg;
    logic        lrst_n_reg;
    frame_word_t shift_reg;
    frame_word_t shift_next;
    logic        shift_en;

    // The serial clock only runs during frames, so the reset is
    // carried over on its edges and takes effect at the third one.
    always_ff @(posedge SCLK)
    begin
        lrst_meta_reg <= NRST;
        lrst_n_reg    <= lrst_meta_reg;
    end

    assign shift_en   = !FRAME_N;
    assign shift_next = shift_en ? {shift_reg[14:0], SDI}
                                 : shift_reg;

    always_ff @(posedge SCLK)
    begin
        if (!lrst_n_reg)
            shift_reg <= '0;
        else
            shift_reg <= shift_next;
    end

    assign SDO = shift_reg[`FRAME_BITS-1];

    // -------------------------------------------------------------------
    // System domain: frame line synchroniser and capture
    // -------------------------------------------------------------------
    logic        frame_meta_reg;
    logic        frame_sync_reg;
    logic        frame_last_reg;
    logic        frame_rise;
    frame_word_t word_reg;
    logic        cmd_wr_reg;

    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
        begin
            frame_meta_reg <= 1'b1;
            frame_sync_reg <= 1'b1;
            frame_last_reg <= 1'b1;
        end
        else
        begin
            frame_meta_reg <= FRAME_N;
            frame_sync_reg <= frame_meta_reg;
            frame_last_reg <= frame_sync_reg;
        end
    end

    assign frame_rise = frame_sync_reg && !frame_last_reg;

    // The shift register holds still while the frame line is high, so
    // the word is taken across once the rise has been synchronised.
    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
        begin
            word_reg   <= '0;
            cmd_wr_reg <= 1'b0;
        end
        else
        begin
            if (frame_rise)
                word_reg <= shift_reg;
            cmd_wr_reg <= frame_rise;
        end
    end

    // -------------------------------------------------------------------
    // Address decode and channels
    // -------------------------------------------------------------------
    ch_addr_t  cmd_addr;
    att_code_t cmd_code;
    logic      addr_known;

    assign cmd_addr   = word_reg[`ADDR_MSB:`ADDR_LSB];
    assign cmd_code   = word_reg[`CODE_MSB:`CODE_LSB];
    assign addr_known = (32'(cmd_addr) < NUM_CH);

    atten_ch_if ch_bus [NUM_CH] ();

    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_ch
        assign ch_bus[i].wr   = cmd_wr_reg && addr_known
                              && (cmd_addr == ch_addr_t'(i));
        assign ch_bus[i].code = cmd_code;
        assign TAP_SEL[i*127 +: 127] = ch_bus[i].tap;
        assign MUTE[i]               = ch_bus[i].mute;

        atten_channel u_channel (
            .clk  (CLK_SYS),
            .nrst (NRST),
            .cmd  (ch_bus[i])
        );
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    sequence s_frame_rise;
        !frame_sync_reg ##1 frame_sync_reg;
    endsequence

    property p_capture;
        @(posedge CLK_SYS) disable iff (!NRST)
        s_frame_rise |=> cmd_wr_reg ##1 !cmd_wr_reg;
    endproperty
    a_capture: assert property (p_capture)
        else $error("Frame line rise did not give one capture pulse.");

    property p_capture_only_on_rise;
        @(posedge CLK_SYS) disable iff (!NRST)
        cmd_wr_reg |-> $past(frame_rise);
    endproperty
    a_capture_only_on_rise: assert property (p_capture_only_on_rise)
        else $error("Capture without a frame line rise.");

    property p_first_channel;
        @(posedge CLK_SYS) disable iff (!NRST)
        cmd_wr_reg && (cmd_addr == 8'h00) |-> ch_bus[0].wr;
    endproperty
    a_first_channel: assert property (p_first_channel)
        else $error("Address zero did not select the first channel.");

    property p_tap_apply;
        @(posedge CLK_SYS) disable iff (!NRST)
        cmd_wr_reg && (cmd_addr == 8'h00) && (cmd_code < `MUTE_CODE)
            |=> !MUTE[0] && TAP_SEL[$past(cmd_code[6:0])];
    endproperty
    a_tap_apply: assert property (p_tap_apply)
        else $error("Code to the first channel did not select its tap.");

    property p_unknown_addr;
        @(posedge CLK_SYS) disable iff (!NRST)
        cmd_wr_reg && !addr_known |=> $stable(MUTE) && $stable(TAP_SEL);
    endproperty
    a_unknown_addr: assert property (p_unknown_addr)
        else $error("Unknown address changed a channel.");

    property p_mute_apply;
        @(posedge CLK_SYS) disable iff (!NRST)
        cmd_wr_reg && (cmd_addr == 8'h00) && (cmd_code >= `MUTE_CODE)
            |=> MUTE[0];
    endproperty
    a_mute_apply: assert property (p_mute_apply)
        else $error("Mute code to the first channel did not mute it.");

    property p_shift_in;
        @(posedge SCLK) disable iff (!lrst_n_reg)
        !FRAME_N |=> shift_reg[0] == $past(SDI);
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("Serial bit not shifted in.");

    property p_shift_hold;
        @(posedge SCLK) disable iff (!lrst_n_reg)
        FRAME_N |=> $stable(shift_reg);
    endproperty
    a_shift_hold: assert property (p_shift_hold)
        else $error("Shift register moved while the frame line was high.");

    property p_cascade;
        @(posedge SCLK) disable iff (!lrst_n_reg)
        !FRAME_N ##1 !FRAME_N |=> SDO == $past(shift_reg[13], 2);
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("Cascade output does not follow the shifted bits.");

endmodule // serial_attenuator_control

/* verif/host_model.sv */
// Host side of the four-wire frame link.
`timescale 1ns/10ps
module host_model
(
    input  wire logic clk,
    input  wire logic sdo,
    output logic      sclk,
    output logic      sdi,
    output logic      frame_n
);
    logic [31:0] trace;

    initial
    begin
        sclk = 1'b0;
        sdi = 1'b0;
        frame_n = 1'b1;
        trace = '0;
    end

    // Data changes after each fall; the released line shows its inverse.
    task automatic shift_bits(input logic [31:0] v);
        for (int i = 31; i >= 0; i--)
        begin
            sdi <= v[i];
            #80 sclk <= 1'b1;
            #80 sclk <= 1'b0;
            trace[i] = sdo;
        end
        sdi <= ~v[0];
    endtask

    task automatic latch(input bit shift_en, input logic [31:0] v);
        @(posedge clk) frame_n <= 1'b0;
        repeat (3) @(posedge clk);
        if (shift_en)
            shift_bits(v);
        @(posedge clk) frame_n <= 1'b1;
        repeat (5) @(posedge clk);
    endtask
endmodule // host_model

/* verif/testbench.sv */
// Self-checking bench of the attenuator control path.
`timescale 1ns/10ps
module testbench;
    import atten_pkg::*;
    logic         CLK_SYS = 1'b0;
    logic         NRST = 1'b0;
    wire logic    SCLK;
    wire logic    SDI;
    wire logic    FRAME_N;
    wire logic    SDO;
    wire logic [253:0] TAP_SEL;
    wire logic [1:0]   MUTE;
    att_code_t    exp_code [2];
    frame_word_t  last_word;
    int           err_count = 0;
    int           samples_checked = 0;

    always #50 CLK_SYS = ~CLK_SYS;

    serial_attenuator_control #(.NUM_CH(2)) serial_attenuator_control_inst
    (
        .CLK_SYS(CLK_SYS), .NRST(NRST), .SCLK(SCLK), .SDI(SDI),
        .FRAME_N(FRAME_N), .SDO(SDO), .TAP_SEL(TAP_SEL), .MUTE(MUTE)
    );

    host_model host_model_inst
    (
        .clk(CLK_SYS), .sdo(SDO), .sclk(SCLK), .sdi(SDI),
        .frame_n(FRAME_N)
    );

    task automatic end_of_test;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [126:0] tap_of(input att_code_t c);
        return (c >= 8'h7f) ? '0 : (127'h1 << c);
    endfunction

    task automatic check_channels;
        for (int i = 0; i < 2; i++)
        begin
            check(MUTE[i], exp_code[i] >= 8'h7f);
            check(TAP_SEL[i*127+:127], tap_of(exp_code[i]));
        end
    endtask

    // Two words per frame: the first leaves on the cascade output.
    task automatic frame(input ch_addr_t a, input att_code_t c);
        frame_word_t w;
        logic [47:0] s;
        w = {a, c};
        s = {last_word, ~w, w};
        host_model_inst.latch(1'b1, {~w, w});
        check(host_model_inst.trace, s[46:15]);
        last_word = w;
        if (a < 2)
            exp_code[a[0]] = c;
        repeat (2) @(posedge CLK_SYS);
        check_channels();
    endtask

    task automatic t_reset;
        fork
            begin
                @(posedge CLK_SYS) NRST <= 1'b0;
                repeat (10) @(posedge CLK_SYS);
                NRST <= 1'b1;
            end
            begin
                @(posedge CLK_SYS);
                host_model_inst.shift_bits(32'h5a5a_c3c3);
            end
        join
        exp_code[0] = 8'h7f;
        exp_code[1] = 8'h7f;
        last_word = '0;
        check_channels();
    endtask

    task automatic t_codes;
        att_code_t codes [8] = '{8'h00, 8'h01, 8'h40, 8'h7e,
                                 8'h7f, 8'h80, 8'hff, 8'h25};
        for (int ch = 0; ch < 2; ch++)
            foreach (codes[k])
                frame(ch[7:0], codes[k]);
    endtask

    task automatic t_bad_addr;
        frame(8'h02, 8'h10);
        frame(8'hff, 8'h00);
    endtask

    task automatic t_ignore;
        frame(8'h00, 8'h33);
        host_model_inst.shift_bits(32'h0000_0000);
        host_model_inst.latch(1'b0, 32'h0000_0000);
        repeat (2) @(posedge CLK_SYS);
        check_channels();
    endtask

    initial
    begin
        #2_000_000;
        err_count++;
        end_of_test();
    end

    initial
    begin
        t_reset();
        t_codes();
        t_bad_addr();
        t_ignore();
        t_reset();
        frame(8'h01, 8'h05);
        end_of_test();
    end
endmodule // testbench
